// ---- rtl/ltcc_top.sv ----
// Purpose: Transmit channel control register and transmit path of one
//   line channel, reached over a classic Wishbone slave.
// Assumes: Link clock and data pins are asynchronous and much slower
//   than clk_i; they are synchronised before use.
// Notes: Registers answer one cycle after the request; unmapped reads
//   return zero and unmapped writes are dropped.
// Functional notes
// RQ1: Monitor-select 1 watches own outputs, 0 watches monitor input pins.
// RQ2: Raise drive fault after 128 idle bit periods; clear on activity.
// RQ3: Error-insert write from 0 to 1 corrupts exactly one PRBS bit.
// RQ4: Error insert only acts with PRBS generator and receiver both enabled.
// RQ5: Error-insert must be cleared before next request; held 1 adds none.
// RQ6: All-ones bit sends unframed continuous ones, ignoring system data.
// RQ7: Edge-select 0 samples rails on falling clock edge, 1 on rising.
// RQ8: Each channel has its own register at index channel-nibble and 4.
// RQ9: Build-out bit enables or disables the transmit pulse shaping output.
// RQ10: Build-out bit is ignored in E3 mode.
// RQ11: Reserved bits read zero and writes to them do nothing.
`timescale 1ns/10ps
`default_nettype none
`include "ltcc_defs.svh"

module ltcc_top #(
  parameter logic [3:0] CH_INDEX = 4'h0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic tx_line_clock_i,
  input wire logic tx_data_pos_rail_i,
  input wire logic tx_data_neg_rail_i,
  input wire logic monitor_in_pos_i,
  input wire logic monitor_in_neg_i,
  output logic tx_line_out_pos_o,
  output logic tx_line_out_neg_o,
  output logic line_buildout_en_o,
  output logic drive_fault_alarm_o,
  output logic irq_o
);
  ltcc_pkg::ltcc_top_s st;
  ltcc_pkg::ltcc_top_s next_st;
  logic [`LTCC_SYNC_W-1:0] pins_s;
  logic clk_s;
  logic pos_s;
  logic neg_s;
  logic mpos_s;
  logic mneg_s;
  logic access;
  logic wr_en;
  logic rd_en;
  logic [3:0] reg_sel;
  logic chan_hit;
  logic bit_edge;
  logic prbs_bit;
  logic prbs_on;
  logic watch_now;
  logic activity;
  logic [7:0] wr_byte;
  logic [2:0] events;
  logic err_arm;

  ltcc_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({tx_line_clock_i, tx_data_pos_rail_i, tx_data_neg_rail_i,
              monitor_in_pos_i, monitor_in_neg_i}),
    .sync_o(pins_s)
  );

  assign {clk_s, pos_s, neg_s, mpos_s, mneg_s} = pins_s;

  ltcc_prbs u_prbs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .adv_i(bit_edge && prbs_on),
    .bit_o(prbs_bit)
  );

  assign access = wb_cyc_i && wb_stb_i && !st.ack;
  assign chan_hit = (wb_adr_i[9:6] == CH_INDEX); // RQ8
  assign reg_sel = wb_adr_i[5:2];
  assign wr_en = access && wb_we_i && wb_sel_i[0] && chan_hit;
  assign rd_en = access && !wb_we_i && chan_hit;
  assign wr_byte = wb_dat_i[7:0];
  assign prbs_on = st.misc[`LTCC_MISC_GEN];

  // Only a rising write arms an error; a held 1 arms nothing.
  assign err_arm = wr_en && reg_sel == `LTCC_IDX_TXCTL &&
                   wr_byte[`LTCC_TC_ERRINS] && !st.txctl[`LTCC_TC_ERRINS] &&
                   st.misc[`LTCC_MISC_GEN] && st.misc[`LTCC_MISC_RX]; // RQ5

  // The selected edge of the synchronised link clock marks one bit period.
  assign bit_edge = st.txctl[`LTCC_TC_EDGE] ? (clk_s && !st.clk_prev)
                                            : (!clk_s && st.clk_prev); // RQ7

  // Internal watch looks at our own pads, external at the monitor pins.
  assign watch_now = st.txctl[`LTCC_TC_INTMON] ?
                     (st.pos_out || st.neg_out) : (mpos_s || mneg_s); // RQ1
  assign activity = st.mon_seen || watch_now;

  always_comb begin
    next_st = st;
    events = '0;
    next_st.ack = access;
    next_st.clk_prev = clk_s;

    if (wr_en && reg_sel == `LTCC_IDX_TXCTL) begin
      next_st.txctl = wr_byte & `LTCC_TC_WMASK; // RQ11
    end
    if (err_arm) begin
      next_st.err_pend = 1'b1; // RQ3 RQ4
    end
    if (wr_en && reg_sel == `LTCC_IDX_MASK) begin
      next_st.mask = wr_byte[2:0];
    end
    if (wr_en && reg_sel == `LTCC_IDX_MISC) begin
      next_st.misc = wr_byte[2:0];
    end

    next_st.rdata = '0;
    if (rd_en) begin
      case (reg_sel)
        `LTCC_IDX_TXCTL: next_st.rdata = {24'h000000, st.txctl}; // RQ11
        `LTCC_IDX_STAT: next_st.rdata = {29'h00000000, st.stat};
        `LTCC_IDX_MASK: next_st.rdata = {29'h00000000, st.mask};
        `LTCC_IDX_MISC: next_st.rdata = {29'h00000000, st.misc};
        `LTCC_IDX_LIVE: next_st.rdata = {31'h00000000, st.alarm};
        default: next_st.rdata = '0;
      endcase
    end

    if (!(st.misc[`LTCC_MISC_GEN] && st.misc[`LTCC_MISC_RX])) begin
      next_st.err_pend = 1'b0; // RQ4
    end

    if (watch_now) begin
      next_st.mon_seen = 1'b1;
    end

    if (bit_edge) begin
      next_st.mon_seen = 1'b0;
      if (st.txctl[`LTCC_TC_ALLONES]) begin
        // Ones alternate polarity so the line stays bipolar.
        next_st.pos_out = st.mark_pol; // RQ6
        next_st.neg_out = !st.mark_pol; // RQ6
        next_st.mark_pol = !st.mark_pol;
      end else if (prbs_on) begin
        next_st.pos_out = (prbs_bit ^ st.err_pend) && st.mark_pol;
        next_st.neg_out = (prbs_bit ^ st.err_pend) && !st.mark_pol;
        if (prbs_bit ^ st.err_pend) begin
          next_st.mark_pol = !st.mark_pol;
        end
        if (st.err_pend) begin
          // A request armed in this very cycle outlives the one consumed.
          next_st.err_pend = err_arm; // RQ3
          events[`LTCC_ST_ERR_DONE] = 1'b1;
        end
      end else begin
        next_st.pos_out = pos_s; // RQ7
        next_st.neg_out = neg_s; // RQ7
      end

      if (activity) begin
        next_st.idle_cnt = '0;
        next_st.alarm = 1'b0; // RQ2
        events[`LTCC_ST_FAULT_CLR] = st.alarm;
      end else if (st.idle_cnt != `LTCC_FAULT_LIMIT) begin
        next_st.idle_cnt = st.idle_cnt + 8'h01;
        if (st.idle_cnt + 8'h01 == `LTCC_FAULT_LIMIT) begin
          next_st.alarm = 1'b1; // RQ2
          events[`LTCC_ST_FAULT_SET] = !st.alarm;
        end
      end
    end

    // A read clears the status; an event in the same cycle still lands.
    if (rd_en && reg_sel == `LTCC_IDX_STAT) begin
      next_st.stat = events;
    end else begin
      next_st.stat = st.stat | events;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.txctl <= `LTCC_TC_RESET;
      st.misc <= `LTCC_MISC_RESET;
      st.stat <= `LTCC_ST_RESET;
      st.mark_pol <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;
  assign tx_line_out_pos_o = st.pos_out;
  assign tx_line_out_neg_o = st.neg_out;
  assign line_buildout_en_o = st.txctl[`LTCC_TC_BUILDOUT] &&
                              !st.misc[`LTCC_MISC_E3]; // RQ9 RQ10
  assign drive_fault_alarm_o = st.alarm;
  assign irq_o = |(st.stat & st.mask);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_resv_bits_zero: assert property ( // RQ11
    (st.txctl & ~`LTCC_TC_WMASK) == 8'h00)
    else $error("Reserved transmit control bits are not zero.");

  a_resv_read_back: assert property ( // RQ11
    rd_en && reg_sel == `LTCC_IDX_TXCTL |=> wb_ack_o &&
    wb_dat_o[7:6] == 2'h0 && !wb_dat_o[3])
    else $error("Reserved bits read back nonzero.");

  a_chan_decode: assert property ( // RQ8
    access && wb_we_i && wb_sel_i[0] && reg_sel == `LTCC_IDX_TXCTL &&
    wb_adr_i[9:6] != CH_INDEX |=> st.txctl == $past(st.txctl))
    else $error("Write to another channel changed this register.");

  a_buildout_e3: assert property ( // RQ10
    st.misc[`LTCC_MISC_E3] |-> !line_buildout_en_o)
    else $error("Build-out active in E3 mode.");

  a_buildout_on: assert property ( // RQ9
    wr_en && reg_sel == `LTCC_IDX_TXCTL && wr_byte[`LTCC_TC_BUILDOUT] &&
    !st.misc[`LTCC_MISC_E3] |=> line_buildout_en_o)
    else $error("Build-out not enabled.");

  a_buildout_off: assert property ( // RQ9
    wr_en && reg_sel == `LTCC_IDX_TXCTL && !wr_byte[`LTCC_TC_BUILDOUT]
    |=> !line_buildout_en_o)
    else $error("Build-out not disabled.");

  a_all_ones: assert property ( // RQ6
    bit_edge && st.txctl[`LTCC_TC_ALLONES] |=>
    (tx_line_out_pos_o != tx_line_out_neg_o))
    else $error("All-ones mode sent a zero.");

  a_edge_sample: assert property ( // RQ7
    bit_edge && !st.txctl[`LTCC_TC_ALLONES] && !prbs_on |=>
    tx_line_out_pos_o == $past(pos_s) && tx_line_out_neg_o == $past(neg_s))
    else $error("System data not sampled on the selected edge.");

  a_monitor_sel: assert property ( // RQ1
    st.txctl[`LTCC_TC_INTMON] && !st.pos_out && !st.neg_out &&
    !st.mon_seen |-> !activity)
    else $error("Internal monitor looked at the monitor pins.");

  a_extmon_pins: assert property ( // RQ1
    !st.txctl[`LTCC_TC_INTMON] && (mpos_s || mneg_s) |-> activity)
    else $error("External monitor ignored the monitor pins.");

  a_fault_raise: assert property ( // RQ2
    bit_edge && !activity && st.idle_cnt == 8'h7F |=> drive_fault_alarm_o)
    else $error("Drive fault not raised after the idle limit.");

  a_fault_clear: assert property ( // RQ2
    bit_edge && activity |=> !drive_fault_alarm_o && st.idle_cnt == 8'h00)
    else $error("Drive fault not cleared on activity.");

  a_fault_idle: assert property ( // RQ2
    $rose(drive_fault_alarm_o) |->
    $past(st.idle_cnt) == (`LTCC_FAULT_LIMIT - 8'h01))
    else $error("Drive fault raised before the idle limit.");

  a_err_gate: assert property ( // RQ4
    $rose(st.err_pend) |-> $past(st.misc[`LTCC_MISC_GEN]) &&
    $past(st.misc[`LTCC_MISC_RX]))
    else $error("Error armed without PRBS enabled.");

  a_err_disarm: assert property ( // RQ4
    !(st.misc[`LTCC_MISC_GEN] && st.misc[`LTCC_MISC_RX]) |=> !st.err_pend)
    else $error("Error request survived a disabled PRBS.");

  a_err_single: assert property ( // RQ3
    st.err_pend && bit_edge && prbs_on && !st.txctl[`LTCC_TC_ALLONES] &&
    !err_arm |=> !st.err_pend && st.stat[`LTCC_ST_ERR_DONE])
    else $error("Error insert not consumed in one bit.");

  a_err_flip: assert property ( // RQ3
    st.err_pend && bit_edge && prbs_on && !st.txctl[`LTCC_TC_ALLONES] |=>
    (tx_line_out_pos_o || tx_line_out_neg_o) == !$past(prbs_bit))
    else $error("Armed error did not invert the pattern bit.");

  a_prbs_pass: assert property ( // RQ3
    !st.err_pend && bit_edge && prbs_on && !st.txctl[`LTCC_TC_ALLONES] |=>
    (tx_line_out_pos_o || tx_line_out_neg_o) == $past(prbs_bit))
    else $error("Pattern bit corrupted without a request.");

  c_fault_raised: cover property ($rose(drive_fault_alarm_o));
  c_error_sent: cover property ($fell(st.err_pend) && prbs_on);
  c_all_ones: cover property (bit_edge && st.txctl[`LTCC_TC_ALLONES]);
  c_irq_seen: cover property ($rose(irq_o));
endmodule // ltcc_top
`default_nettype wire

// ---- rtl/ltcc_defs.svh ----
// Purpose: Constants of the transmit channel control block.
// Assumes: Word-indexed register map, one register per 32-bit word.
// Notes: Register index = {channel, low nibble}; byte address = 4 * index.
`ifndef LTCC_DEFS_SVH
`define LTCC_DEFS_SVH

`define LTCC_IDX_TXCTL 4'h4
`define LTCC_IDX_STAT 4'h8
`define LTCC_IDX_MASK 4'h9
`define LTCC_IDX_MISC 4'hA
`define LTCC_IDX_LIVE 4'hB

`define LTCC_TC_BUILDOUT 0
`define LTCC_TC_EDGE 1
`define LTCC_TC_ALLONES 2
`define LTCC_TC_ERRINS 4
`define LTCC_TC_INTMON 5
`define LTCC_TC_WMASK 8'h37
`define LTCC_TC_RESET 8'h00

`define LTCC_MISC_GEN 0
`define LTCC_MISC_RX 1
`define LTCC_MISC_E3 2
`define LTCC_MISC_RESET 3'h0

`define LTCC_ST_FAULT_SET 0
`define LTCC_ST_FAULT_CLR 1
`define LTCC_ST_ERR_DONE 2
`define LTCC_ST_RESET 3'h0

`define LTCC_FAULT_LIMIT 8'h80
`define LTCC_PRBS_SEED 15'h7FFF
`define LTCC_PRBS_TAP_A 14
`define LTCC_PRBS_TAP_B 13
`define LTCC_SYNC_W 5

`endif

// ---- rtl/ltcc_pkg.sv ----
// Purpose: State types of the transmit channel control block.
// Assumes: ltcc_defs.svh supplies the widths.
// Notes: One packed struct per module holds all of its state.
`include "ltcc_defs.svh"

package ltcc_pkg;

  typedef struct packed {
    logic [`LTCC_SYNC_W-1:0] stage1;
    logic [`LTCC_SYNC_W-1:0] stage2;
  } ltcc_sync_s;

  typedef struct packed {
    logic [14:0] lfsr;
  } ltcc_prbs_s;

  typedef struct packed {
    logic [7:0] txctl;
    logic [2:0] misc;
    logic [2:0] stat;
    logic [2:0] mask;
    logic ack;
    logic [31:0] rdata;
    logic clk_prev;
    logic err_pend;
    logic mark_pol;
    logic pos_out;
    logic neg_out;
    logic [7:0] idle_cnt;
    logic alarm;
    logic mon_seen;
  } ltcc_top_s;

endpackage

// ---- rtl/ltcc_sync.sv ----
// Purpose: Two-flop synchroniser for the link pins.
// Assumes: Inputs are asynchronous to clk_i.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
`include "ltcc_defs.svh"

module ltcc_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`LTCC_SYNC_W-1:0] async_i,
  output logic [`LTCC_SYNC_W-1:0] sync_o
);
  ltcc_pkg::ltcc_sync_s st;
  ltcc_pkg::ltcc_sync_s next_st;

  always_comb begin
    next_st.stage1 = async_i;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.stage2;
endmodule // ltcc_sync
`default_nettype wire

// ---- rtl/ltcc_prbs.sv ----
// Purpose: Pseudo-random pattern generator for the transmit path.
// Assumes: adv_i pulses once per transmitted bit.
// Notes: Error insertion is applied by the caller on bit_o.
`timescale 1ns/10ps
`default_nettype none
`include "ltcc_defs.svh"

module ltcc_prbs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic adv_i,
  output logic bit_o
);
  ltcc_pkg::ltcc_prbs_s st;
  ltcc_pkg::ltcc_prbs_s next_st;

  always_comb begin
    next_st = st;
    if (adv_i) begin
      next_st.lfsr = {st.lfsr[13:0],
        st.lfsr[`LTCC_PRBS_TAP_A] ^ st.lfsr[`LTCC_PRBS_TAP_B]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.lfsr <= `LTCC_PRBS_SEED;
    end else begin
      st <= next_st;
    end
  end

  assign bit_o = st.lfsr[`LTCC_PRBS_TAP_A];
endmodule // ltcc_prbs
`default_nettype wire

// ---- test/ltcc_framer.sv ----
// Purpose: System-side framer model driving the dual-rail transmit data.
// Assumes: A free-running 200 ns link clock, unrelated in phase to clk_i.
// Notes: Data is launched on the edge opposite to the sampling edge.
`timescale 1ns/10ps
`default_nettype none

module ltcc_framer (
  input wire logic sample_rise_i,
  input wire logic pos_i,
  input wire logic neg_i,
  output logic clk_o,
  output logic pos_o,
  output logic neg_o
);
  initial begin
    clk_o = 1'b0;
    pos_o = 1'b0;
    neg_o = 1'b0;
    #37;
    forever begin
      #100 clk_o = ~clk_o;
      // Launching on the other edge keeps data stable at the sampling edge.
      if (clk_o != sample_rise_i) begin
        pos_o = pos_i;
        neg_o = neg_i;
      end
    end
  end
endmodule // ltcc_framer

`default_nettype wire

// ---- test/tb.sv ----
// Purpose: Self-checking bench of the transmit channel control block.
// Assumes: Monitor pins loop back from the line outputs unless broken.
// Notes: One bit period is 8 cycles of clk_i.
`timescale 1ns/10ps
`default_nettype none

module tb;
  typedef struct packed {
    logic [3:0] ch;
    logic [3:0] nib;
    logic [7:0] wd;
    logic [7:0] ex;
  } ltcc_row_s;
  ltcc_row_s rows [8] = '{'{4'h0, 4'h4, 8'hFF, 8'h37},
    '{4'h0, 4'h4, 8'h00, 8'h00}, '{4'h0, 4'h4, 8'h25, 8'h25},
    '{4'h1, 4'h4, 8'h12, 8'h00}, '{4'h0, 4'h3, 8'h55, 8'h00},
    '{4'h0, 4'h9, 8'h01, 8'h01}, '{4'h0, 4'hA, 8'h04, 8'h04},
    '{4'h0, 4'h4, 8'h03, 8'h03}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] dat = 32'h0;
  logic sys_pos = 1'b1;
  logic sys_neg = 1'b0;
  logic link_ok = 1'b1;
  logic edge_sel = 1'b0;
  logic [31:0] r;
  logic [1:0] prev;
  int bad_count = 0;
  int checked = 0;
  wire logic [31:0] dat_o;
  wire logic ack, lclk, lpos, lneg, opos, oneg, bo, alarm, irq;
  wire logic mpos = opos & link_ok;
  wire logic mneg = oneg & link_ok;

  ltcc_framer fr (.sample_rise_i(edge_sel), .pos_i(sys_pos),
    .neg_i(sys_neg), .clk_o(lclk), .pos_o(lpos), .neg_o(lneg));

  ltcc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .tx_line_clock_i(lclk), .tx_data_pos_rail_i(lpos),
    .tx_data_neg_rail_i(lneg), .monitor_in_pos_i(mpos),
    .monitor_in_neg_i(mneg), .tx_line_out_pos_o(opos),
    .tx_line_out_neg_o(oneg), .line_buildout_en_o(bo),
    .drive_fault_alarm_o(alarm), .irq_o(irq));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic single cycle; a write lands and read data is taken at ack.
  task automatic wb(input logic w, input logic [3:0] ch,
                    input logic [3:0] nib, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {ch, nib, 2'b00};
    dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    r = dat_o;
    cyc <= 1'b0;
  endtask

  task automatic bits(input int n);
    repeat (n * 8) @(posedge clk_i);
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("ack", 0, ack);
    chk("irq", 0, irq);
    chk("alarm", 0, alarm);
    wb(0, 0, 4'h4, 0);
    chk("txctl reset", 0, r);
    $display("test reset done");
    foreach (rows[i]) begin
      wb(1, rows[i].ch, rows[i].nib, rows[i].wd);
      wb(0, rows[i].ch, rows[i].nib, 0);
      chk("row read", {24'h0, rows[i].ex}, r);
    end
    $display("test rows done");
    chk("buildout e3", 0, bo);
    wb(1, 0, 4'hA, 0);
    @(posedge clk_i);
    chk("buildout", 1, bo);
    $display("test buildout done");
    for (int e = 0; e < 2; e++) begin
      edge_sel <= e[0];
      wb(1, 0, 4'h4, {6'h0, e[0], 1'b0});
      sys_pos <= 1'b0;
      sys_neg <= 1'b1;
      bits(4);
      chk("sys data", 1, {opos, oneg});
      sys_pos <= 1'b1;
      sys_neg <= 1'b0;
      bits(4);
      chk("sys data", 2, {opos, oneg});
    end
    $display("test system data done");
    sys_pos <= 1'b0;
    wb(1, 0, 4'h4, 8'h04);
    bits(2);
    prev = {opos, oneg};
    for (int k = 0; k < 3; k++) begin
      bits(1);
      chk("all ones", 3, {opos, oneg} ^ prev);
      prev = {opos, oneg};
    end
    $display("test all ones done");
    link_ok <= 1'b0;
    bits(120);
    chk("alarm early", 0, alarm);
    bits(14);
    chk("alarm", 1, alarm);
    chk("irq", 1, irq);
    wb(0, 0, 4'hB, 0);
    chk("live", 1, r);
    wb(1, 0, 4'h4, 8'h24);
    bits(3);
    chk("alarm internal", 0, alarm);
    wb(0, 0, 4'h8, 0);
    chk("status", 3, r);
    @(posedge clk_i);
    chk("irq cleared", 0, irq);
    link_ok <= 1'b1;
    sys_pos <= 1'b1;
    $display("test drive monitor done");
    wb(1, 0, 4'hA, 8'h03);
    wb(1, 0, 4'h4, 8'h10);
    bits(3);
    chk("irq masked", 0, irq);
    wb(0, 0, 4'h8, 0);
    chk("err status", 4, r);
    wb(1, 0, 4'h4, 8'h10);
    bits(3);
    wb(0, 0, 4'h8, 0);
    chk("err held", 0, r);
    wb(1, 0, 4'h4, 8'h00);
    wb(1, 0, 4'hA, 8'h01);
    wb(1, 0, 4'h4, 8'h10);
    bits(3);
    wb(0, 0, 4'h8, 0);
    chk("err gated", 0, r);
    $display("test error insert done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("line after reset", 0, {opos, oneg});
    chk("alarm after reset", 0, alarm);
    chk("irq after reset", 0, irq);
    chk("buildout after reset", 0, bo);
    wb(0, 0, 4'hA, 0);
    chk("misc after reset", 0, r);
    wb(0, 0, 4'h4, 0);
    chk("txctl after reset", 0, r);
    $display("test mid reset done");
    summarize();
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
endmodule // tb

`default_nettype wire
